// *** verilog/sar_adc_consts.svh ***
// Operation
// - serial mode off: shared pins carry bits 8..11
// - frame marker only with internal shift clock
// - marker high during read, invert low
// - marker low during read, invert high
// - read flag only in external-clock serial
// - unfinished read at conversion end: pulse flag
// - bits 12..15 always outputs
// - busy from start until result latched
// - outputs driven only while select and read low
// - chip select gates the external shift clock
// - reset pin high aborts conversion
// - power-down: finish conversion, then stop starting
// - start high at acquisition end: wait falling edge
// - start low at acquisition end: convert now
// - internal reference on unless disabled
// - reference buffer on unless disabled
// - serial result shifted msb first
// - external clock: data changes on update edge
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define ADC_BITS        16
`define WORD_MSB        4'hF
`define CLK_PERIOD_NS   10
`define ACQ_TIME_NS     250
`define SETTLE_TIME_NS  40
`define CYC_LEAST(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERR_PULSE_CYC   8'h08
`define ISCLK_HALF_CYC  4'h2
`define TIMER_W         12

// synchroniser lanes
`define SYNC_LANES      13
`define LN_CNV          0
`define LN_PD           1
`define LN_RSTPIN       2
`define LN_CMP          3
`define LN_CS_N         4
`define LN_RD_N         5
`define LN_DONE         6
`define LN_REFDIS       7
`define LN_BUFDIS       8
`define LN_PORTSEL      9
`define LN_CLKSEL       10
`define LN_SYNCINV      11
`define LN_SPARE        12
// idle pin levels: start, select and read high
`define SYNC_IDLE       13'h0031

// shared pin positions on the result bus
`define PIN_SDO         8
`define PIN_SCLK        9
`define PIN_SYNC        10
`define PIN_ERR         11
`define PIN_HI_LSB      12

`endif

// *** verilog/sar_adc_pkg.sv ***
`include "sar_adc_consts.svh"
`default_nettype none
package sar_adc_pkg;
   typedef logic [`ADC_BITS-1:0] word_t;
   typedef logic [3:0]           bit_idx_t;

   typedef enum logic [1:0] {ST_ACQ, ST_WAIT_FALL, ST_CONV, ST_PDOWN} conv_state_e;

   typedef struct packed {
      logic [`SYNC_LANES-1:0] syncA;
      logic [`SYNC_LANES-1:0] syncB;
      logic                   cnvPrev;
      conv_state_e            state;
      logic [`TIMER_W-1:0]    timer;
      bit_idx_t               bitIdx;
      word_t                  trial;
      word_t                  result;
      logic                   busy;
      logic                   newData;
      logic                   readPend;
      logic [7:0]             errCnt;
      logic                   resyncTgl;
      logic                   doneSeen;
      logic                   intActive;
      bit_idx_t               intBit;
      logic [3:0]             intDiv;
      logic                   intClk;
      logic                   intSdo;
   } sys_state_s;

   typedef struct packed {
      logic [1:0] rstSync;
      logic [1:0] resync;
      logic       resyncSeen;
      bit_idx_t   cnt;
      logic       sdo;
      logic       doneTgl;
   } link_state_s;

   function automatic logic bitOf(input word_t w, input bit_idx_t idx);
      bitOf = w[`WORD_MSB - idx];
   endfunction : bitOf
endpackage : sar_adc_pkg
`default_nettype wire

// *** verilog/shift_link_if.sv ***
`default_nettype none
interface shift_link_if;
   import sar_adc_pkg::*;
   word_t word;
   logic  resyncTgl;
   logic  doneTgl;
   logic  sdo;
   modport sys  (output word, output resyncTgl, input doneTgl, input sdo);
   modport link (input word, input resyncTgl, output doneTgl, output sdo);
endinterface : shift_link_if
`default_nettype wire

// *** verilog/serial_link_shifter.sv ***
`include "sar_adc_consts.svh"
`default_nettype none
module serial_link_shifter (
   input  wire logic shiftClk,          // host serial clock
   input  wire logic shiftClockInvert,  // swap update edge
   input  wire logic csN,               // chip select, host-timed with clock
   input  wire logic rstB,              // system reset, async to this clock
   shift_link_if.link link              // to system domain
);
   import sar_adc_pkg::*;

   link_state_s lnk_reg;
   link_state_s lnk_next;
   logic        updClk;

   // static config; a change mid-frame would make a stray edge
   assign updClk = shiftClk ^ shiftClockInvert;

   always_comb begin
      lnk_next         = lnk_reg;
      lnk_next.rstSync = {lnk_reg.rstSync[0], rstB};
      lnk_next.resync  = {lnk_reg.resync[0], link.resyncTgl};
      if (!lnk_reg.rstSync[1]) begin
         lnk_next.cnt        = 4'h0;
         lnk_next.sdo        = 1'b0;
         lnk_next.doneTgl    = 1'b0;
         lnk_next.resyncSeen = lnk_reg.resync[1];
      end else if (lnk_reg.resync[1] != lnk_reg.resyncSeen) begin
         // aborted read: realign to the new word's msb
         lnk_next.resyncSeen = lnk_reg.resync[1];
         lnk_next.cnt        = 4'h0;
      end else if (!csN) begin
         // word is replaced at conversion end even mid-read; the system side then toggles resync
         lnk_next.sdo = bitOf(link.word, lnk_reg.cnt);
         lnk_next.cnt = lnk_reg.cnt + 4'h1;
         if (lnk_reg.cnt == `WORD_MSB) begin
            lnk_next.doneTgl = ~lnk_reg.doneTgl;
         end
      end
   end

   always_ff @(posedge updClk) begin
      lnk_reg <= lnk_next;
   end

   assign link.sdo     = lnk_reg.sdo;
   assign link.doneTgl = lnk_reg.doneTgl;
endmodule : serial_link_shifter
`default_nettype wire

// *** verilog/sar_adc_ctrl.sv ***
`include "sar_adc_consts.svh"
`default_nettype none
module sar_adc_ctrl #(
   parameter int ACQ_NS    = `ACQ_TIME_NS,   // acquisition phase length
   parameter int SETTLE_NS = `SETTLE_TIME_NS // dac settle before compare
) (
   input  wire logic               clk_sys,          // system clock
   input  wire logic               rst_b,            // sync reset, low active
   input  wire logic               resetPin,         // device reset pin, high
   input  wire logic               convert_start_n,  // conversion start pin
   input  wire logic               powerDownReq,     // power-down pin
   input  wire logic               cmpIn,            // comparator: input >= dac
   input  wire logic               portStyleSelect,  // high = serial port
   input  wire logic               clockSourceSelect,// high = external clock
   input  wire logic               frameMarkerInvert,// marker polarity
   input  wire logic               shiftClockInvert, // external update edge
   input  wire logic               internalRefDisable,// reference off
   input  wire logic               refBufferDisable, // buffer off
   input  wire logic               csN,              // chip select
   input  wire logic               rdN,              // read
   input  wire logic               shiftClk,         // external serial clock
   output logic [`ADC_BITS-1:0]    dataOut,          // result bus levels
   output logic [`ADC_BITS-1:0]    dataOe,           // result bus enables
   output logic                    busy,             // conversion running
   output logic                    sampleHold,       // high = hold
   output sar_adc_pkg::word_t      dacCode,          // trial code to dac
   output logic                    refEnable,        // internal reference on
   output logic                    bufEnable,        // reference buffer on
   output logic                    lowPower          // reduced power state
);
   import sar_adc_pkg::*;

   localparam logic [`TIMER_W-1:0] ACQ_CYC =
      `TIMER_W'(`CYC_LEAST(ACQ_NS) < 1 ? 1 : `CYC_LEAST(ACQ_NS));
   localparam logic [`TIMER_W-1:0] SETTLE_CYC =
      `TIMER_W'(`CYC_LEAST(SETTLE_NS) < 1 ? 1 : `CYC_LEAST(SETTLE_NS));

   sys_state_s st_reg;
   sys_state_s st_next;

   shift_link_if link ();

   serial_link_shifter u_shifter (
      .shiftClk         (shiftClk),
      .shiftClockInvert (shiftClockInvert),
      .csN              (csN),
      .rstB             (rst_b),
      .link             (link.link)
   );

   assign link.word      = st_reg.result;
   assign link.resyncTgl = st_reg.resyncTgl;

   // synchronised pin levels, second stage only
   logic cnvS;
   logic pdS;
   logic rstPinS;
   logic cmpS;
   logic busEnS;
   logic doneS;
   logic serialS;
   logic extClkS;
   logic syncInvS;

   always_comb begin
      cnvS     = st_reg.syncB[`LN_CNV];
      pdS      = st_reg.syncB[`LN_PD];
      rstPinS  = st_reg.syncB[`LN_RSTPIN];
      cmpS     = st_reg.syncB[`LN_CMP];
      busEnS   = !st_reg.syncB[`LN_CS_N] && !st_reg.syncB[`LN_RD_N];
      doneS    = st_reg.syncB[`LN_DONE];
      serialS  = st_reg.syncB[`LN_PORTSEL];
      extClkS  = st_reg.syncB[`LN_CLKSEL];
      syncInvS = st_reg.syncB[`LN_SYNCINV];
   end

   // conversion sequencer and readout
   always_comb begin
      st_next       = st_reg;
      st_next.syncA = {1'b0,
                       frameMarkerInvert,
                       clockSourceSelect,
                       portStyleSelect,
                       refBufferDisable,
                       internalRefDisable,
                       link.doneTgl,
                       rdN,
                       csN,
                       cmpIn,
                       resetPin,
                       powerDownReq,
                       convert_start_n};
      st_next.syncB   = st_reg.syncA;
      st_next.cnvPrev = cnvS;

      // external read: opens when the bus is enabled, closes on 16 bits
      if (doneS != st_reg.doneSeen) begin
         st_next.doneSeen = doneS;
         st_next.readPend = 1'b0;
      end
      if (busEnS && serialS && extClkS && !st_reg.readPend && st_reg.newData) begin
         st_next.readPend = 1'b1;
         st_next.newData  = 1'b0;
      end
      if (st_reg.errCnt != 8'h00) begin
         st_next.errCnt = st_reg.errCnt - 8'h01;
      end

      unique case (st_reg.state)
         ST_ACQ: begin
            st_next.timer = st_reg.timer + `TIMER_W'(1);
            if (st_reg.timer >= ACQ_CYC - `TIMER_W'(1)) begin
               st_next.timer = '0;
               if (pdS) begin
                  st_next.state = ST_PDOWN;
               end else if (cnvS) begin
                  st_next.state = ST_WAIT_FALL;
               end else begin
                  st_next.state  = ST_CONV;
                  st_next.busy   = 1'b1;
                  st_next.bitIdx = `WORD_MSB;
                  st_next.trial  = word_t'(1) << `WORD_MSB;
               end
            end
         end
         ST_WAIT_FALL: begin
            if (pdS) begin
               st_next.state = ST_PDOWN;
            end else if (st_reg.cnvPrev && !cnvS) begin
               st_next.state  = ST_CONV;
               st_next.busy   = 1'b1;
               st_next.bitIdx = `WORD_MSB;
               st_next.trial  = word_t'(1) << `WORD_MSB;
            end
         end
         ST_CONV: begin
            st_next.timer = st_reg.timer + `TIMER_W'(1);
            if (st_reg.timer >= SETTLE_CYC - `TIMER_W'(1)) begin
               st_next.timer = '0;
               if (!cmpS) begin
                  st_next.trial[st_reg.bitIdx] = 1'b0;
               end
               if (st_reg.bitIdx == 4'h0) begin
                  // one word per conversion, latched as busy falls
                  st_next.result = st_next.trial;
                  st_next.busy   = 1'b0;
                  st_next.state  = ST_ACQ;
                  st_next.newData = 1'b1;
                  if (st_reg.readPend && serialS && extClkS) begin
                     st_next.errCnt    = `ERR_PULSE_CYC;
                     st_next.readPend  = 1'b0;
                     st_next.resyncTgl = ~st_reg.resyncTgl;
                  end
               end else begin
                  st_next.bitIdx = st_reg.bitIdx - 4'h1;
                  st_next.trial[st_reg.bitIdx - 4'h1] = 1'b1;
               end
            end
         end
         ST_PDOWN: begin
            if (!pdS) begin
               st_next.state = ST_ACQ;
               st_next.timer = '0;
            end
         end
      endcase

      // internal-clock read: device makes the clock from clk_sys
      if (st_reg.intActive) begin
         st_next.intDiv = st_reg.intDiv + 4'h1;
         if (st_reg.intDiv >= `ISCLK_HALF_CYC - 4'h1) begin
            st_next.intDiv = 4'h0;
            st_next.intClk = ~st_reg.intClk;
            if (st_reg.intClk) begin
               if (st_reg.intBit == `WORD_MSB) begin
                  st_next.intActive = 1'b0;
               end else begin
                  st_next.intBit = st_reg.intBit + 4'h1;
                  st_next.intSdo = bitOf(st_reg.result, st_reg.intBit + 4'h1);
               end
            end
         end
      end else if (busEnS && serialS && !extClkS && !st_reg.busy && st_reg.newData) begin
         st_next.intActive = 1'b1;
         st_next.newData   = 1'b0;
         st_next.intBit    = 4'h0;
         st_next.intDiv    = 4'h0;
         st_next.intClk    = 1'b0;
         st_next.intSdo    = bitOf(st_reg.result, 4'h0);
      end

      // pin reset aborts whatever is running; result is kept
      if (rstPinS) begin
         st_next.state     = ST_ACQ;
         st_next.timer     = '0;
         st_next.busy      = 1'b0;
         st_next.trial     = '0;
         st_next.intActive = 1'b0;
         st_next.intClk    = 1'b0;
         st_next.readPend  = 1'b0;
         st_next.newData   = 1'b0;
         st_next.errCnt    = 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_reg          <= '0;
         st_reg.state    <= ST_ACQ;
         // idle levels, else the bus looks enabled until the pins are seen
         st_reg.syncA    <= `SYNC_IDLE;
         st_reg.syncB    <= `SYNC_IDLE;
         st_reg.cnvPrev  <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // output pins
   logic frameMark;
   always_comb begin
      frameMark = st_reg.intActive ^ syncInvS;
      dataOut   = st_reg.result;
      dataOe    = '0;
      if (!serialS) begin
         dataOe = {`ADC_BITS{busEnS}};
      end else begin
         dataOut[`PIN_SDO]  = extClkS ? link.sdo : st_reg.intSdo;
         dataOut[`PIN_SCLK] = st_reg.intClk;
         dataOut[`PIN_SYNC] = frameMark;
         dataOut[`PIN_ERR]  = extClkS && (st_reg.errCnt != 8'h00);
         dataOe[`PIN_SDO]   = busEnS;
         dataOe[`PIN_SCLK]  = busEnS && !extClkS;
         dataOe[`PIN_SYNC]  = busEnS && !extClkS;
         dataOe[`PIN_ERR]   = busEnS && extClkS;
         dataOe[`ADC_BITS-1:`PIN_HI_LSB] = {(`ADC_BITS - `PIN_HI_LSB){busEnS}};
      end
   end

   assign busy       = st_reg.busy;
   assign sampleHold = (st_reg.state == ST_CONV);
   assign dacCode    = st_reg.trial;
   assign refEnable  = !st_reg.syncB[`LN_REFDIS];
   assign bufEnable  = !st_reg.syncB[`LN_BUFDIS];
   assign lowPower   = (st_reg.state == ST_PDOWN);
endmodule : sar_adc_ctrl
`default_nettype wire

// *** tb/host_link_model.sv ***
`default_nettype none
module host_link_model (
   output logic      sclk, // host shift clock
   input  wire logic sdo   // serial result line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial sclk = 1'b0;
   // clock idles low between frames; one bit per 64 ns period
   task automatic shiftBits(input int n, output logic [15:0] w);
      w = 16'h0000;
      repeat (n) begin
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
         w = {w[14:0], sdo};
      end
   endtask : shiftBits
endmodule : host_link_model
`default_nettype wire

// *** tb/sar_adc_ctrl_chk.sv ***
`include "sar_adc_consts.svh"
`default_nettype none
module sar_adc_ctrl_chk #(
   parameter int SETTLE_NS = `SETTLE_TIME_NS // step length
) (
   input wire logic                 clk_sys,            // clock
   input wire logic                 rst_b,              // reset
   input wire logic                 resetPin,           // abort
   input wire logic                 convert_start_n,    // start
   input wire logic                 csN,                // select
   input wire logic                 rdN,                // read
   input wire logic                 portStyleSelect,    // serial
   input wire logic                 clockSourceSelect,  // ext clock
   input wire logic                 internalRefDisable, // ref off
   input wire logic                 refBufferDisable,   // buf off
   input wire logic [`ADC_BITS-1:0] dataOut,            // levels
   input wire logic [`ADC_BITS-1:0] dataOe,             // enables
   input wire logic                 busy,               // converting
   input wire logic                 sampleHold,         // hold
   input wire logic                 refEnable,          // ref on
   input wire logic                 bufEnable,          // buf on
   input wire logic                 lowPower            // power down
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] busyLen;
   logic       aborted;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   // an aborted conversion is allowed to end early
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         busyLen <= 8'h00;
         aborted <= 1'b0;
      end else begin
         busyLen <= busy ? busyLen + 8'h01 : 8'h00;
         aborted <= busy & (aborted | resetPin);
      end
   end
   oe_gate_a: assert property ($rose(|dataOe) |-> $past(!csN && !rdN))
      else $error("bus enabled without select and read");
   hi_bits_a: assert property (|dataOe[11:0] |-> &dataOe[15:12])
      else $error("top bits not driven");
   busy_len_a: assert property ($fell(busy) && !aborted |->
      busyLen == `ADC_BITS * `CYC_LEAST(SETTLE_NS))
      else $error("busy length wrong");
   hold_start_a: assert property ($rose(busy) |-> $rose(sampleHold))
      else $error("hold not entered with busy");
   start_wait_a: assert property (convert_start_n [*5] |-> !$rose(busy))
      else $error("started without falling edge");
   abort_busy_a: assert property (resetPin [*5] |-> !busy)
      else $error("busy survives reset pin");
   pd_block_a: assert property (lowPower |-> !busy)
      else $error("conversion in power down");
   ref_on_a: assert property ($stable(internalRefDisable) [*8] |-> refEnable == !internalRefDisable)
      else $error("reference enable wrong");
   buf_on_a: assert property ($stable(refBufferDisable) [*8] |-> bufEnable == !refBufferDisable)
      else $error("buffer enable wrong");
   err_pulse_a: assert property (
      portStyleSelect && clockSourceSelect && $rose(dataOut[11]) |-> dataOut[11] [*8])
      else $error("error pulse too short");
   cover property ($fell(busy));
   cover property (&dataOe);
   cover property (lowPower);
endmodule : sar_adc_ctrl_chk
bind sar_adc_ctrl sar_adc_ctrl_chk #(.SETTLE_NS(SETTLE_NS)) sar_adc_ctrl_chk_inst (
   .clk_sys, .rst_b, .resetPin, .convert_start_n, .csN, .rdN, .portStyleSelect,
   .clockSourceSelect, .internalRefDisable, .refBufferDisable, .dataOut, .dataOe, .busy,
   .sampleHold, .refEnable, .bufEnable, .lowPower);
`default_nettype wire

// *** tb/sar_adc_conversion_and_output_ctrl_test.sv ***
`default_nettype none
module sar_adc_conversion_and_output_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sar_adc_pkg::*;
   logic      clk_sys, rst_b, resetPin, convert_start_n, powerDownReq, portStyleSelect;
   logic      clockSourceSelect, frameMarkerInvert, internalRefDisable, refBufferDisable;
   logic      csN, rdN, busy, sampleHold, refEnable, bufEnable, lowPower;
   wire logic cmpIn, shiftClk, sdoPin;
   word_t     dataOut, dataOe, dacCode, level, w, junk;
   int        fails = 0, comparisons = 0, cycles = 0, errHits = 0, errBase = 0;
   word_t     corner[4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};

   sar_adc_ctrl sar_adc_ctrl_inst (.clk_sys, .rst_b, .resetPin, .convert_start_n,
      .powerDownReq, .cmpIn, .portStyleSelect, .clockSourceSelect, .frameMarkerInvert,
      .shiftClockInvert(1'b0), .internalRefDisable, .refBufferDisable, .csN, .rdN,
      .shiftClk, .dataOut, .dataOe, .busy, .sampleHold, .dacCode, .refEnable, .bufEnable,
      .lowPower);
   host_link_model host_link_model_inst (.sclk(shiftClk), .sdo(sdoPin));
   assign cmpIn = level >= dacCode;
   // no pull on the line: a released pin reads as the wrong level
   assign sdoPin = dataOe[8] ? dataOut[8] : !dataOut[8];

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (portStyleSelect && clockSourceSelect && dataOe[11] && dataOut[11])
         errHits <= errHits + 1;
   end

   function automatic word_t sarWord(input word_t lvl);
      word_t r;
      r = 16'h0000;
      for (int i = 15; i >= 0; i--)
         if (lvl >= (r | (16'h0001 << i)))
            r = r | (16'h0001 << i);
      return r;
   endfunction : sarWord
   task automatic check(input string what, input word_t seen, input word_t exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic waitBusy(input logic lvl);
      for (int i = 0; i < 300 && busy !== lvl; i++)
         tick(1);
      check("busy", {15'h0000, busy}, {15'h0000, lvl});
   endtask : waitBusy
   task automatic startConv(input word_t lvl);
      level <= lvl;
      convert_start_n <= 1'b0;
      waitBusy(1'b1);
      convert_start_n <= 1'b1;
   endtask : startConv
   task automatic convert(input word_t lvl);
      startConv(lvl);
      waitBusy(1'b0);
      tick(2);
   endtask : convert
   task automatic readPar(input word_t lvl);
      csN <= 1'b0;
      tick(5);
      check("oe cs only", dataOe, 16'h0000);
      rdN <= 1'b0;
      tick(5);
      check("oe", dataOe, 16'hFFFF);
      check("word", dataOut, sarWord(lvl));
      csN <= 1'b1;
      rdN <= 1'b1;
      tick(5);
      check("oe off", dataOe, 16'h0000);
   endtask : readPar
   task automatic readInt(input word_t lvl);
      int   n;
      logic prev;
      n = 0;
      prev = 1'b1;
      w = 16'h0000;
      csN <= 1'b0;
      rdN <= 1'b0;
      for (int i = 0; i < 400 && n < 16; i++) begin
         tick(1);
         if (dataOe[10] && (dataOut[10] ^ frameMarkerInvert) && dataOut[9] && !prev) begin
            w = {w[14:0], dataOut[8]};
            n++;
         end
         prev = dataOut[9];
      end
      check("oe top", {12'h000, dataOe[15:12]}, 16'h000F);
      check("no flag oe", {15'h0000, dataOe[11]}, 16'h0000);
      check("int word", w, sarWord(lvl));
      csN <= 1'b1;
      rdN <= 1'b1;
   endtask : readInt
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic runTests();
      {rst_b, resetPin, powerDownReq, portStyleSelect, clockSourceSelect} = 5'h00;
      {frameMarkerInvert, internalRefDisable, refBufferDisable} = 3'h0;
      {convert_start_n, csN, rdN} = 3'h7;
      level = 16'h0000;
      w = $urandom(32'h585D);
      // link side needs three edges of its own clock inside reset
      fork
         host_link_model_inst.shiftBits(3, junk);
         tick(20);
      join
      rst_b <= 1'b1;
      tick(3);
      check("oe reset", dataOe, 16'h0000);
      repeat (4) begin
         {internalRefDisable, refBufferDisable} <= 2'($urandom);
         tick(8);
         check("ref", {15'h0000, refEnable}, {15'h0000, !internalRefDisable});
         check("buf", {15'h0000, bufEnable}, {15'h0000, !refBufferDisable});
      end
      $display("reference test done");
      for (int k = 0; k < 7; k++) begin
         w = (k < 4) ? corner[k] : 16'($urandom);
         convert(w);
         readPar(w);
      end
      tick(40);
      check("busy idle", {15'h0000, busy}, 16'h0000);
      convert(16'h1234);
      $display("parallel test done");
      portStyleSelect <= 1'b1;
      for (int v = 0; v < 2; v++) begin
         frameMarkerInvert <= v[0];
         w = 16'($urandom);
         convert(w);
         readInt(w);
      end
      clockSourceSelect <= 1'b1;
      w = 16'($urandom);
      convert(w);
      rdN <= 1'b0;
      tick(4);
      host_link_model_inst.shiftBits(3, junk);
      tick(1);
      csN <= 1'b0;
      tick(5);
      host_link_model_inst.shiftBits(16, junk);
      check("ext word", junk, sarWord(w));
      check("no marker", {15'h0000, dataOe[10]}, 16'h0000);
      errBase = errHits;
      convert(16'h4321);
      check("no flag", {15'h0000, errHits != errBase}, 16'h0000);
      host_link_model_inst.shiftBits(4, junk);
      tick(1);
      convert(16'h00FF);
      tick(10);
      check("flag", {15'h0000, errHits != errBase}, 16'h0001);
      {csN, rdN, portStyleSelect, clockSourceSelect} <= 4'hC;
      $display("serial test done");
      startConv(16'hA5A5);
      powerDownReq <= 1'b1;
      waitBusy(1'b0);
      convert_start_n <= 1'b0;
      tick(60);
      check("pd busy", {15'h0000, busy}, 16'h0000);
      check("low power", {15'h0000, lowPower}, 16'h0001);
      {powerDownReq, convert_start_n} <= 2'h1;
      readPar(16'hA5A5);
      startConv(16'h5555);
      tick(10);
      resetPin <= 1'b1;
      tick(6);
      check("abort", {15'h0000, busy}, 16'h0000);
      resetPin <= 1'b0;
      tick(3);
      convert(16'h2222);
      readPar(16'h2222);
      $display("power and abort test done");
   endtask : runTests

   // the scenarios race a cycle ceiling; whichever ends first closes the run
   initial begin
      fork
         runTests();
         wait (cycles >= 30000);
      join_any
      if (cycles >= 30000) begin
         fails++;
         $display("BAD timeout expected %0d seen %0d", 30000, cycles);
      end
      summarize();
   end
endmodule : sar_adc_conversion_and_output_ctrl_test
`default_nettype wire
